// File: rah_link_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// sensor link model
// ----------------------------------------
module rah_link_model (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // command and payload from handler
    input  wire logic              lnk_cmd_valid,
    output logic                   lnk_cmd_ready,
    input  wire rah_pkg::rah_cmd_t lnk_cmd,
    input  wire logic              lnk_wr_valid,
    output logic                   lnk_wr_ready,
    input  wire logic [7:0]        lnk_wr_data,
    input  wire logic              lnk_wr_last,
    // read data and completion
    output logic                   lnk_rd_valid,
    input  wire logic              lnk_rd_ready,
    output logic [7:0]             lnk_rd_data,
    output logic                   lnk_rd_last,
    output logic                   lnk_done,
    output logic                   lnk_err,
    output logic [15:0]            lnk_err_code
);
    import rah_pkg::*;
    logic [7:0] msg [4] = '{8'h74, 8'h65, 8'h73, 8'h74};
    logic [7:0] wr_q [$];
    rah_cmd_t   cmd_q;
    logic [1:0] n_ff;
    logic [4:0] hold_ff;
    logic       rdy_ff, rd_on_ff, done_ff;
    // slow on purpose, and payload stalls long enough to fill the fifo
    assign lnk_cmd_ready = rdy_ff;
    assign lnk_wr_ready  = (hold_ff == 5'h00);
    assign lnk_rd_valid  = rd_on_ff;
    // idle data line shows the inverse, never a stale copy
    assign lnk_rd_data   = rd_on_ff ? msg[n_ff] : ~msg[n_ff];
    assign lnk_rd_last   = rd_on_ff & (n_ff == 2'h3);
    assign lnk_done      = done_ff;
    assign lnk_err       = done_ff & ~|cmd_q.index;
    assign lnk_err_code  = 16'h80A0;
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            {rdy_ff, rd_on_ff, done_ff, n_ff, hold_ff} <= '0;
        else
        begin
            done_ff <= (lnk_wr_valid & lnk_wr_ready & lnk_wr_last) | (lnk_rd_last & lnk_rd_ready);
            rdy_ff  <= lnk_cmd_valid & ~rdy_ff;
            if (hold_ff != 5'h00)
                hold_ff <= hold_ff - 5'h01;
            if (lnk_cmd_valid & rdy_ff)
            begin
                cmd_q    <= lnk_cmd;
                rd_on_ff <= ~lnk_cmd.write;
                n_ff     <= 2'h0;
                hold_ff  <= 5'h1E;
            end
            if (lnk_wr_valid & lnk_wr_ready)
                wr_q.push_back(lnk_wr_data);
            if (rd_on_ff & lnk_rd_ready)
                n_ff <= n_ff + 2'h1;
            if (lnk_rd_last & lnk_rd_ready)
                rd_on_ff <= 1'b0;
        end
    end
endmodule // rah_link_model
`default_nettype wire

// File: rah_pkg.sv
package rah_pkg;

    // ----------------------------------------
    // access point and fixed header values
    // ----------------------------------------
    localparam logic [15:0] RAH_CAP_INDEX   = 16'hB400;
    localparam logic [7:0]  RAH_FUNC_CODE   = 8'h08;
    localparam logic [15:0] RAH_PFI_CODE    = 16'hFE4A;
    localparam int          RAH_NPORT       = 8;
    localparam logic [7:0]  RAH_PORT_MIN    = 8'h01;
    localparam logic [7:0]  RAH_PORT_MAX    = 8'h08;

    // ----------------------------------------
    // control and status codings
    // ----------------------------------------
    localparam logic [7:0]  RAH_CTRL_CANCEL = 8'h00;
    localparam logic [7:0]  RAH_CTRL_IDLE   = 8'h01;
    localparam logic [7:0]  RAH_CTRL_WRITE  = 8'h02;
    localparam logic [7:0]  RAH_CTRL_READ   = 8'h03;
    localparam logic [7:0]  RAH_STAT_DONE   = 8'h00;
    localparam logic [7:0]  RAH_STAT_IDLE   = 8'h01;
    localparam logic [7:0]  RAH_STAT_ERR    = 8'h80;

    // ----------------------------------------
    // local error descriptor codes
    // ----------------------------------------
    localparam logic [15:0] RAH_ERR_SHORT   = 16'h8001;
    localparam logic [15:0] RAH_ERR_FUNC    = 16'h8002;
    localparam logic [15:0] RAH_ERR_PFI     = 16'h8003;
    localparam logic [15:0] RAH_ERR_PORT    = 16'h8004;
    localparam logic [15:0] RAH_ERR_CTRL    = 16'h8005;

    // ----------------------------------------
    // header byte positions and response counts
    // ----------------------------------------
    localparam logic [2:0]  RAH_HB_FUNC     = 3'h0;
    localparam logic [2:0]  RAH_HB_PORT     = 3'h1;
    localparam logic [2:0]  RAH_HB_PFI_HI   = 3'h2;
    localparam logic [2:0]  RAH_HB_PFI_LO   = 3'h3;
    localparam logic [2:0]  RAH_HB_CTRL     = 3'h4;
    localparam logic [2:0]  RAH_HB_IDX_HI   = 3'h5;
    localparam logic [2:0]  RAH_HB_IDX_LO   = 3'h6;
    localparam logic [2:0]  RAH_HB_SUB      = 3'h7;
    localparam logic [3:0]  RAH_HDR_LEN     = 4'h8;
    localparam logic [3:0]  RAH_RSP_ERR_HI  = 4'h8;
    localparam logic [3:0]  RAH_RSP_ERR_LO  = 4'h9;
    localparam int          RAH_FIFO_DEPTH  = 16;

    typedef enum logic [2:0] {
        RAH_ST_IDLE   = 3'b000,
        RAH_ST_HDR    = 3'b001,
        RAH_ST_EVAL   = 3'b010,
        RAH_ST_CMD    = 3'b011,
        RAH_ST_STREAM = 3'b100,
        RAH_ST_WAIT   = 3'b101,
        RAH_ST_RESP   = 3'b110
    } rah_state_t;

    typedef struct packed {
        logic [7:0]  port;
        logic        write;
        logic [15:0] index;
        logic [7:0]  sub;
    } rah_cmd_t;

    typedef struct packed {
        logic        last;
        logic [7:0]  data;
    } rah_byte_t;

endpackage

// File: rah_record_access_handler.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// byte fifo, depth must be a power of two
// ----------------------------------------
module rah_fifo #(
    parameter int W  = 9,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    // control
    input  wire logic          flush,
    output logic [AW:0]        level,
    // fill side
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    // drain side
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data
);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_ff;
    logic [AW:0]  rd_ptr_ff;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    assign level     = wr_ptr_ff - rd_ptr_ff;
    assign in_ready  = level != (AW+1)'(D);
    assign out_valid = level != '0;
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else if (flush)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end

    fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        level <= (AW+1)'(D)) else $error("fifo level beyond depth");
endmodule // rah_fifo

// ----------------------------------------
// record access handler
// ----------------------------------------
module rah_record_access_handler #(
    parameter int NPORT = rah_pkg::RAH_NPORT,
    parameter int DEPTH = rah_pkg::RAH_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // record write from controller
    input  wire logic             rec_wr_valid,
    output logic                  rec_wr_ready,
    input  wire logic [7:0]       rec_wr_data,
    input  wire logic             rec_wr_last,
    input  wire logic [15:0]      rec_wr_index,
    output logic                  rec_wr_reject_ff,
    // record read from controller
    input  wire logic             rec_rd_valid,
    output logic                  rec_rd_ready,
    input  wire logic [15:0]      rec_rd_index,
    output logic                  rec_rd_reject_ff,
    output logic                  rsp_valid_ff,
    input  wire logic             rsp_ready,
    output logic [7:0]            rsp_data_ff,
    output logic                  rsp_last_ff,
    // sensor link side
    output logic                  lnk_cmd_valid,
    input  wire logic             lnk_cmd_ready,
    output rah_pkg::rah_cmd_t     lnk_cmd,
    output logic [NPORT-1:0]      lnk_port_sel_ff,
    output logic                  lnk_wr_valid,
    input  wire logic             lnk_wr_ready,
    output logic [7:0]            lnk_wr_data,
    output logic                  lnk_wr_last,
    input  wire logic             lnk_rd_valid,
    output logic                  lnk_rd_ready,
    input  wire logic [7:0]       lnk_rd_data,
    input  wire logic             lnk_rd_last,
    input  wire logic             lnk_done,
    input  wire logic             lnk_err,
    input  wire logic [15:0]      lnk_err_code,
    // state
    output logic                  busy
);
    import rah_pkg::*;
    localparam int LW = $clog2(DEPTH);

    rah_state_t  st_ff, nxt_st;
    logic [7:0]  hdr_ff [8];
    logic [2:0]  hcnt_ff;
    logic        short_ff, tail_ff, drop_ff, nxt_drop;
    logic [7:0]  status_ff, nxt_status;
    logic [15:0] err_code_ff, nxt_err_code;
    logic [3:0]  rcnt_ff;
    logic        rsp_end_ff;
    logic [LW:0] fifo_level;
    logic        fifo_in_ready, fifo_out_valid;
    rah_byte_t   fifo_in_word, fifo_out_word;

    // ----------------------------------------
    // request intake decode
    // ----------------------------------------
    wire       wr_take    = rec_wr_valid & rec_wr_ready;
    wire       drop_take  = wr_take & drop_ff;
    wire       start_take = wr_take & !drop_ff & (st_ff == RAH_ST_IDLE);
    wire       idx_bad    = rec_wr_index != RAH_CAP_INDEX;
    wire       hdr_take   = (start_take & !idx_bad)
                          | (wr_take & !drop_ff & (st_ff == RAH_ST_HDR));
    wire [2:0] hdr_slot   = (st_ff == RAH_ST_IDLE) ? RAH_HB_FUNC : hcnt_ff;
    wire       hdr_done   = hdr_take & (rec_wr_last | (hdr_slot == RAH_HB_SUB));
    wire       rd_take    = rec_rd_valid & rec_rd_ready;
    wire       rd_bad     = rec_rd_index != RAH_CAP_INDEX;
    wire       rsp_fin    = rsp_valid_ff & rsp_ready & rsp_last_ff;

    // ----------------------------------------
    // header field checks
    // ----------------------------------------
    wire [7:0] ctrl      = hdr_ff[RAH_HB_CTRL];
    wire       func_ok   = hdr_ff[RAH_HB_FUNC] == RAH_FUNC_CODE;
    wire       pfi_ok    = {hdr_ff[RAH_HB_PFI_HI], hdr_ff[RAH_HB_PFI_LO]} == RAH_PFI_CODE;
    wire       port_ok   = (hdr_ff[RAH_HB_PORT] >= RAH_PORT_MIN)
                         & (hdr_ff[RAH_HB_PORT] <= RAH_PORT_MAX);
    wire       is_write  = ctrl == RAH_CTRL_WRITE;
    wire       is_rw     = is_write | (ctrl == RAH_CTRL_READ);
    wire       has_pay   = is_write & !tail_ff;

    // command carries index and sub-index together, msb byte first
    assign lnk_cmd.port  = hdr_ff[RAH_HB_PORT];
    assign lnk_cmd.write = is_write;
    assign lnk_cmd.index = {hdr_ff[RAH_HB_IDX_HI], hdr_ff[RAH_HB_IDX_LO]};
    assign lnk_cmd.sub   = hdr_ff[RAH_HB_SUB];
    assign lnk_cmd_valid = st_ff == RAH_ST_CMD;
    assign busy          = st_ff != RAH_ST_IDLE;

    // ----------------------------------------
    // handshakes and fifo steering
    // ----------------------------------------
    // read only taken when no write is in flight, write wins a tie
    assign rec_rd_ready = (st_ff == RAH_ST_IDLE) & !drop_ff & !rec_wr_valid;
    assign rec_wr_ready = drop_ff | (st_ff == RAH_ST_IDLE) | (st_ff == RAH_ST_HDR)
                        | ((st_ff == RAH_ST_STREAM) & fifo_in_ready);

    wire fifo_in_valid  = ((st_ff == RAH_ST_STREAM) & rec_wr_valid)
                        | ((st_ff == RAH_ST_WAIT) & lnk_rd_valid);
    assign fifo_in_word = (st_ff == RAH_ST_STREAM) ? rah_byte_t'({rec_wr_last, rec_wr_data})
                                                   : rah_byte_t'({lnk_rd_last, lnk_rd_data});
    assign lnk_rd_ready = (st_ff == RAH_ST_WAIT) & fifo_in_ready;
    assign lnk_wr_valid = (st_ff == RAH_ST_STREAM) & fifo_out_valid;
    assign lnk_wr_data  = fifo_out_word.data;
    assign lnk_wr_last  = fifo_out_word.last;
    wire   lnk_wr_take  = lnk_wr_valid & lnk_wr_ready;
    // stale read data must not leak into the next answer
    wire   fifo_flush   = (st_ff == RAH_ST_EVAL)
                        | ((st_ff == RAH_ST_WAIT) & lnk_done & lnk_err);

    // ----------------------------------------
    // response source selection
    // ----------------------------------------
    wire       in_hdr   = rcnt_ff < RAH_HDR_LEN;
    wire       err_rsp  = status_ff == RAH_STAT_ERR;
    wire       fifo_src = !in_hdr & !err_rsp;
    wire       rsp_load = (st_ff == RAH_ST_RESP) & !rsp_end_ff & (!rsp_valid_ff | rsp_ready);
    wire [7:0] hdr_byte = (rcnt_ff[2:0] == RAH_HB_CTRL) ? status_ff : hdr_ff[rcnt_ff[2:0]];
    wire [7:0] err_byte = (rcnt_ff == RAH_RSP_ERR_HI) ? err_code_ff[15:8] : err_code_ff[7:0];
    wire [7:0] src_byte = in_hdr ? hdr_byte : (err_rsp ? err_byte : fifo_out_word.data);
    wire       src_last = in_hdr ? ((rcnt_ff[2:0] == RAH_HB_SUB) & !err_rsp & (fifo_level == '0))
                       : (err_rsp ? (rcnt_ff == RAH_RSP_ERR_LO) : (fifo_level == (LW+1)'(1)));
    wire       fifo_out_ready = (st_ff == RAH_ST_STREAM) ? lnk_wr_ready : (rsp_load & fifo_src);

    rah_fifo #(.W($bits(rah_byte_t)), .D(DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .flush     (fifo_flush),
        .level     (fifo_level),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_word)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_status   = status_ff;
        nxt_err_code = err_code_ff;
        nxt_drop     = drop_ff & !(drop_take & rec_wr_last);
        case (st_ff)
            RAH_ST_IDLE:
            begin
                if (start_take & idx_bad & !rec_wr_last)
                    nxt_drop = 1'b1;
                if (hdr_done)
                    nxt_st = RAH_ST_EVAL;
                else if (hdr_take)
                    nxt_st = RAH_ST_HDR;
                else if (rd_take & !rd_bad)
                    nxt_st = RAH_ST_RESP;
            end
            RAH_ST_HDR:
                if (hdr_done)
                    nxt_st = RAH_ST_EVAL;
            RAH_ST_EVAL:
            begin
                nxt_st     = RAH_ST_IDLE;
                nxt_drop   = !tail_ff;
                nxt_status = RAH_STAT_ERR;
                if (short_ff)
                    nxt_err_code = RAH_ERR_SHORT;
                else if (ctrl == RAH_CTRL_CANCEL)
                    nxt_status = RAH_STAT_DONE;
                else if (ctrl == RAH_CTRL_IDLE)
                    nxt_status = RAH_STAT_IDLE;
                else if (!is_rw)
                    nxt_err_code = RAH_ERR_CTRL;
                else if (!func_ok)
                    nxt_err_code = RAH_ERR_FUNC;
                else if (!pfi_ok)
                    nxt_err_code = RAH_ERR_PFI;
                else if (!port_ok)
                    nxt_err_code = RAH_ERR_PORT;
                else
                begin
                    nxt_st     = RAH_ST_CMD;
                    nxt_status = status_ff;
                    nxt_drop   = !tail_ff & !is_write;
                end
            end
            RAH_ST_CMD:
                if (lnk_cmd_ready)
                    nxt_st = has_pay ? RAH_ST_STREAM : RAH_ST_WAIT;
            RAH_ST_STREAM:
                if (lnk_wr_take & lnk_wr_last)
                    nxt_st = RAH_ST_WAIT;
            RAH_ST_WAIT:
                if (lnk_done)
                begin
                    nxt_st       = RAH_ST_IDLE;
                    nxt_status   = lnk_err ? RAH_STAT_ERR : RAH_STAT_DONE;
                    nxt_err_code = lnk_err ? lnk_err_code : err_code_ff;
                end
            RAH_ST_RESP:
                if (rsp_fin)
                    nxt_st = RAH_ST_IDLE;
            default:
                nxt_st = RAH_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff            <= RAH_ST_IDLE;
            status_ff        <= RAH_STAT_IDLE;
            err_code_ff      <= '0;
            drop_ff          <= 1'b0;
            rec_wr_reject_ff <= 1'b0;
            rec_rd_reject_ff <= 1'b0;
        end
        else
        begin
            st_ff            <= nxt_st;
            status_ff        <= nxt_status;
            err_code_ff      <= nxt_err_code;
            drop_ff          <= nxt_drop;
            rec_wr_reject_ff <= start_take & idx_bad;
            rec_rd_reject_ff <= rd_take & rd_bad;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hdr_ff   <= '{default: '0};
            hcnt_ff  <= '0;
            short_ff <= 1'b0;
            tail_ff  <= 1'b0;
        end
        else if (hdr_take)
        begin
            hdr_ff[hdr_slot] <= rec_wr_data;
            hcnt_ff          <= hdr_slot + 3'h1;
            short_ff         <= rec_wr_last & (hdr_slot != RAH_HB_SUB);
            tail_ff          <= rec_wr_last;
        end
    end

    // one flop per link, so the select never glitches
    for (genvar i = 0; i < NPORT; i++)
    begin : g_port
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
                lnk_port_sel_ff[i] <= 1'b0;
            else if (st_ff == RAH_ST_EVAL)
                lnk_port_sel_ff[i] <= hdr_ff[RAH_HB_PORT] == 8'(i + 1);
        end
    end

    // ----------------------------------------
    // response output stage
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= '0;
            rsp_last_ff  <= 1'b0;
            rsp_end_ff   <= 1'b0;
            rcnt_ff      <= '0;
        end
        else if (rd_take)
        begin
            rsp_end_ff <= 1'b0;
            rcnt_ff    <= '0;
        end
        else if (rsp_load)
        begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff  <= src_byte;
            rsp_last_ff  <= src_last;
            rsp_end_ff   <= src_last;
            rcnt_ff      <= rcnt_ff + (fifo_src ? 4'h0 : 4'h1);
        end
        else if (rsp_ready)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_last_ff  <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_hdr_end;
        hdr_take && (hdr_slot == RAH_HB_SUB) ##1 st_ff == RAH_ST_EVAL;
    endsequence
    sequence s_eval_cancel;
        st_ff == RAH_ST_EVAL && !short_ff && ctrl == RAH_CTRL_CANCEL;
    endsequence

    bad_index_drop_a: assert property (start_take && idx_bad |=>
        rec_wr_reject_ff && st_ff == RAH_ST_IDLE) else $error("bad index not rejected");
    port_route_a: assert property ($rose(lnk_cmd_valid) |->
        $onehot(lnk_port_sel_ff) && lnk_port_sel_ff[lnk_cmd.port[2:0] - 3'h1])
        else $error("link select does not match port");
    sub_index_a: assert property (s_hdr_end ##1 st_ff == RAH_ST_CMD |->
        lnk_cmd.sub == $past(rec_wr_data, 2)) else $error("sub-index lost");
    index_order_a: assert property (hdr_take && hdr_slot == RAH_HB_IDX_HI |=>
        lnk_cmd.index[15:8] == $past(rec_wr_data)) else $error("index byte order");
    write_cmd_a: assert property (st_ff == RAH_ST_EVAL && !short_ff && is_write
        && func_ok && pfi_ok && port_ok |=> lnk_cmd_valid && lnk_cmd.write)
        else $error("write not issued");
    cancel_release_a: assert property (s_eval_cancel |=>
        status_ff == RAH_STAT_DONE && st_ff == RAH_ST_IDLE && !lnk_cmd_valid)
        else $error("cancel not released");
    link_err_stat_a: assert property (st_ff == RAH_ST_WAIT && lnk_done && lnk_err
        |=> status_ff == RAH_STAT_ERR && err_code_ff == $past(lnk_err_code))
        else $error("error status missing");
    status_slot_a: assert property (rsp_load && in_hdr && rcnt_ff[2:0] == RAH_HB_CTRL
        |=> rsp_valid_ff && rsp_data_ff == status_ff) else $error("status byte wrong");
    read_order_a: assert property (rd_take && !rd_bad |=> st_ff == RAH_ST_RESP
        && !rec_rd_ready) else $error("read taken mid request");
    reserved_ctrl_a: assert property (st_ff == RAH_ST_EVAL && !short_ff && ctrl > RAH_CTRL_READ
        |=> status_ff == RAH_STAT_ERR && err_code_ff == RAH_ERR_CTRL && !lnk_cmd_valid)
        else $error("reserved control accepted");
endmodule // rah_record_access_handler

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// record access handler bench
// ----------------------------------------
module tb_top;
    import rah_pkg::*;
    typedef logic [7:0] rah_bq_t [$];
    logic        ref_clk, rst_b, rec_wr_valid, rec_wr_last, rec_rd_valid, rsp_ready, busy;
    logic        rec_wr_ready, rec_wr_reject_ff, rec_rd_ready, rec_rd_reject_ff;
    logic        rsp_valid_ff, rsp_last_ff, lnk_cmd_valid, lnk_cmd_ready, lnk_done, lnk_err;
    logic        lnk_wr_valid, lnk_wr_ready, lnk_wr_last, lnk_rd_valid, lnk_rd_ready, lnk_rd_last;
    logic [7:0]  rec_wr_data, rsp_data_ff, lnk_wr_data, lnk_rd_data, lnk_port_sel_ff, sel_q;
    logic [15:0] rec_wr_index, rec_rd_index, lnk_err_code;
    rah_cmd_t    lnk_cmd;
    int          n_mismatch = 0, samples_checked = 0, n_wrej = 0, n_rrej = 0, cyc = 0;
    rah_record_access_handler uut (.ref_clk, .rst_b, .rec_wr_valid, .rec_wr_ready, .rec_wr_data,
        .rec_wr_last, .rec_wr_index, .rec_wr_reject_ff, .rec_rd_valid, .rec_rd_ready,
        .rec_rd_index, .rec_rd_reject_ff, .rsp_valid_ff, .rsp_ready, .rsp_data_ff, .rsp_last_ff,
        .lnk_cmd_valid, .lnk_cmd_ready, .lnk_cmd, .lnk_port_sel_ff, .lnk_wr_valid, .lnk_wr_ready,
        .lnk_wr_data, .lnk_wr_last, .lnk_rd_valid, .lnk_rd_ready, .lnk_rd_data, .lnk_rd_last,
        .lnk_done, .lnk_err, .lnk_err_code, .busy);
    rah_link_model lm (.ref_clk, .rst_b, .lnk_cmd_valid, .lnk_cmd_ready, .lnk_cmd, .lnk_wr_valid,
        .lnk_wr_ready, .lnk_wr_data, .lnk_wr_last, .lnk_rd_valid, .lnk_rd_ready, .lnk_rd_data,
        .lnk_rd_last, .lnk_done, .lnk_err, .lnk_err_code);
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        n_wrej += rec_wr_reject_ff;
        n_rrej += rec_rd_reject_ff;
        if (lnk_cmd_valid & lnk_cmd_ready)
            sel_q = lnk_port_sel_ff;
        if (cyc == 20000)
        begin
            n_mismatch++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask
    // big-endian 16-bit fields, fixed order
    function automatic rah_bq_t hdr(logic [7:0] f, p, logic [15:0] pfi, logic [7:0] c,
                                    logic [15:0] idx, logic [7:0] sub);
        return '{f, p, pfi[15:8], pfi[7:0], c, idx[15:8], idx[7:0], sub};
    endfunction
    task automatic wr_rec(input logic [15:0] idx, input rah_bq_t b, output int st);
        st = 0;
        foreach (b[i])
        begin
            {rec_wr_valid, rec_wr_data, rec_wr_last, rec_wr_index} = {1'b1, b[i], i == b.size() - 1, idx};
            #1;
            while (!rec_wr_ready)
            begin
                st++;
                @(posedge ref_clk);
                #2;
            end
            @(posedge ref_clk);
            #1;
        end
        rec_wr_valid = 1'b0;
    endtask
    task automatic rd_rec(input logic [15:0] idx, output rah_bq_t q);
        q = {};
        {rec_rd_valid, rec_rd_index} = {1'b1, idx};
        #1;
        while (!rec_rd_ready)
        begin
            @(posedge ref_clk);
            #2;
        end
        @(posedge ref_clk);
        #1 rec_rd_valid = 1'b0;
        if (idx != RAH_CAP_INDEX)
            return;
        do
        begin
            @(posedge ref_clk) #1;
            if (rsp_valid_ff)
                q.push_back(rsp_data_ff);
        end
        while (!rsp_last_ff);
    endtask
    // request record first, then collect at the same access point
    task automatic xfer(input rah_bq_t b, output rah_bq_t r);
        int st;
        wr_rec(RAH_CAP_INDEX, b, st);
        while (busy)
            @(posedge ref_clk) #1;
        rd_rec(RAH_CAP_INDEX, r);
    endtask
    task automatic t_reject();
        int st;
        rah_bq_t r;
        wr_rec(16'hB401, hdr(8'h08, 8'h01, 16'hFE4A, 8'h03, 16'h0001, 8'h00), st);
        rd_rec(16'hB3FF, r);
        repeat (2) @(posedge ref_clk);
        #1 chk("wr_reject", 16'(n_wrej), 16'h0001);
        chk("rd_reject", 16'(n_rrej), 16'h0001);
    endtask
    task automatic t_write();
        rah_bq_t h = hdr(8'h08, 8'h04, 16'hFE4A, 8'h02, 16'h0018, 8'h00), p, r;
        int st;
        for (int i = 0; i < 20; i++)
            p.push_back(8'h40 + 8'(i));
        wr_rec(RAH_CAP_INDEX, {h, p}, st);
        chk("fifo_full_stall", 16'(st > 8), 16'h0001);
        while (busy)
            @(posedge ref_clk) #1;
        chk("wr_count", 16'(lm.wr_q.size()), 16'h0014);
        foreach (p[i])
            chk("wr_byte", {8'h00, lm.wr_q[i]}, {8'h00, p[i]});
        chk("cmd_write", 16'(lm.cmd_q.write), 16'h0001);
        chk("cmd_index", lm.cmd_q.index, 16'h0018);
        chk("port_sel", {8'h00, sel_q}, 16'h0008);
        rd_rec(RAH_CAP_INDEX, r);
        chk("wr_status", {8'h00, r[4]}, {8'h00, RAH_STAT_DONE});
        chk("wr_port_echo", {8'h00, r[1]}, 16'h0004);
    endtask
    task automatic t_read();
        rah_bq_t r;
        xfer(hdr(8'h08, 8'h08, 16'hFE4A, 8'h03, 16'h7FFF, 8'hFF), r);
        chk("rd_len", 16'(r.size()), 16'h000C);
        chk("rd_status", {8'h00, r[4]}, {8'h00, RAH_STAT_DONE});
        chk("rd_data", {r[8], r[11]}, 16'h7474);
        chk("rd_sub", {lm.cmd_q.sub, 7'h00, lm.cmd_q.write}, 16'hFF00);
        chk("rd_port", {lm.cmd_q.port, sel_q}, 16'h0880);
    endtask
    task automatic t_errors();
        logic [15:0] code [7] = '{RAH_ERR_SHORT, RAH_ERR_FUNC, RAH_ERR_PFI, RAH_ERR_PORT,
                                  RAH_ERR_PORT, RAH_ERR_CTRL, 16'h80A0};
        rah_bq_t h, r;
        for (int i = 0; i < 7; i++)
        begin
            h = hdr(i == 1 ? 8'h09 : 8'h08, i == 3 ? 8'h00 : (i == 4 ? 8'h09 : 8'h01),
                    i == 2 ? 16'hFE4B : 16'hFE4A, i == 5 ? 8'h04 : 8'h03, {16{i != 6}}, 8'h00);
            if (i == 0)
                h = h[0:4];
            xfer(h, r);
            chk("err_status", {8'h00, r[4]}, {8'h00, RAH_STAT_ERR});
            chk("err_code", {r[8], r[9]}, code[i]);
        end
    endtask
    task automatic t_cancel_idle();
        rah_bq_t r;
        int st;
        wr_rec(RAH_CAP_INDEX, hdr(8'h08, 8'h02, 16'hFE4A, 8'h03, 16'h0005, 8'h01), st);
        while (busy)
            @(posedge ref_clk) #1;
        for (int c = 0; c < 2; c++)
        begin
            xfer(hdr(8'h08, 8'h02, 16'hFE4A, 8'(c), 16'h0005, 8'h01), r);
            chk("ci_status", {8'h00, r[4]}, 16'(c));
            chk("ci_len", 16'(r.size()), 16'h0008);
        end
    endtask
    initial
    begin
        {rst_b, rec_wr_valid, rec_wr_last, rec_rd_valid, rsp_ready} = 5'h01;
        {rec_wr_data, rec_wr_index, rec_rd_index} = '0;
        repeat (12) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        @(posedge ref_clk);
        #1 t_reject();
        t_write();
        t_read();
        t_errors();
        t_cancel_idle();
        results();
    end
endmodule // tb_top
`default_nettype wire
